// [hw/multiphase_tuning_registers.sv]
// tuning register bank of the multi-phase buck controller
`timescale 1ns/1ps
module multiphase_tuning_registers (
   input  wire logic                     clk_sys,
   input  wire logic                     resetn,
   input  wire tuning_pkg::reg_req_t     req,
   output logic [7:0]                    rdata,
   input  wire logic [7:0]               lock_value,
   input  wire logic                     shed_unlock,
   input  wire logic [2:0]               deglitch_code,
   input  wire logic                     power_state_high,
   input  wire logic                     power_state_low,
   input  wire logic                     diode_emulation_mode,
   input  wire logic [7:0]               zero_current,
   output logic [7:0]                    middle_level,
   output logic [7:0]                    floating,
   output logic                          automatic_phase_shedding,
   output tuning_pkg::tuning_cfg_t       cfg
);
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic ps_high;
   logic ps_low;

   level_sync u_sync_high (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .pin     (power_state_high),
      .level   (ps_high)
   );

   level_sync u_sync_low (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .pin     (power_state_low),
      .level   (ps_low)
   );

   // ----------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------
   logic [7:0] middle_q;
   logic [7:0] phases_q;
   logic [7:0] quick_q;
   logic [7:0] balance_q;
   logic [7:0] shed_q;
   logic [7:0] gain2_q;

   logic unlocked;
   logic shed_ok;
   logic wr_mid;
   logic wr_ph;
   logic wr_quick;
   logic wr_bal;
   logic wr_shed;
   logic wr_gain;

   // lock value and 0x2d live in other banks; they arrive as levels
   assign unlocked = (lock_value != tuning_pkg::LOCK_CODE);
   assign shed_ok  = unlocked & (ps_high | shed_unlock);

   assign wr_mid  = req.we & unlocked
                  & (req.addr == tuning_pkg::OFF_MIDDLE_DRIVE);
   assign wr_ph   = req.we & unlocked
                  & (req.addr == tuning_pkg::OFF_PHASES_RAMP);
   assign wr_quick = req.we & unlocked
                  & (req.addr == tuning_pkg::OFF_QUICK_RESP);
   assign wr_bal  = req.we & unlocked
                  & (req.addr == tuning_pkg::OFF_BALANCE);
   assign wr_gain = req.we & unlocked
                  & (req.addr == tuning_pkg::OFF_GAIN_SECOND);
   assign wr_shed = req.we & shed_ok
                  & (req.addr == tuning_pkg::OFF_SHED_DELAY);

   // rejected writes simply hold the stored value
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         middle_q  <= tuning_pkg::RST_MIDDLE_DRIVE;
         phases_q  <= tuning_pkg::RST_PHASES_RAMP;
         quick_q   <= tuning_pkg::RST_QUICK_RESP;
         balance_q <= tuning_pkg::RST_BALANCE;
         shed_q    <= tuning_pkg::RST_SHED_DELAY;
         gain2_q   <= tuning_pkg::RST_GAIN_SECOND;
      end else begin
         if (wr_mid) begin
            middle_q <= req.wdata & tuning_pkg::MASK_MIDDLE_DRIVE;
         end
         if (wr_ph) begin
            phases_q <= req.wdata & tuning_pkg::MASK_PHASES_RAMP;
         end
         if (wr_quick) begin
            quick_q <= req.wdata & tuning_pkg::MASK_QUICK_RESP;
         end
         if (wr_bal) begin
            balance_q <= req.wdata & tuning_pkg::MASK_BALANCE;
         end
         if (wr_shed) begin
            shed_q <= req.wdata & tuning_pkg::MASK_SHED_DELAY;
         end
         if (wr_gain) begin
            gain2_q <= req.wdata & tuning_pkg::MASK_GAIN_SECOND;
         end
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   logic [7:0] rdata_d;

   always_comb begin
      unique case (req.addr)
         tuning_pkg::OFF_MIDDLE_DRIVE: rdata_d = middle_q;
         tuning_pkg::OFF_PHASES_RAMP:  rdata_d = phases_q;
         tuning_pkg::OFF_QUICK_RESP:   rdata_d = quick_q;
         tuning_pkg::OFF_BALANCE:      rdata_d = balance_q;
         tuning_pkg::OFF_SHED_DELAY:   rdata_d = shed_q;
         tuning_pkg::OFF_GAIN_SECOND:  rdata_d = gain2_q;
         default:                      rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rdata <= 8'h00;
      end else begin
         rdata <= rdata_d;
      end
   end

   // ----------------------------------------------------------------
   // decoded configuration
   // ----------------------------------------------------------------
   logic [2:0] ph_code;
   logic [3:0] ramp;
   logic [3:0] g1_q4;
   logic [3:0] total_q4;
   logic [9:0] shed_us;

   assign ph_code = phases_q[tuning_pkg::LSB_LOW_PHASES +: 3];
   assign ramp    = phases_q[3:0];

   // first factor in quarters: 4,3,2,1
   assign g1_q4 = 4'h4 - {2'b00,
                  balance_q[tuning_pkg::LSB_GAIN_FIRST +: 2]};

   // second factor scales the quarters; the largest result, 8/4, fits in 4 bits
   always_comb begin
      unique case (gain2_q[1:0])
         2'b01:   total_q4 = 4'(g1_q4 << 1);
         2'b10:   total_q4 = 4'(g1_q4 >> 1);
         default: total_q4 = g1_q4;
      endcase
   end

   always_comb begin
      unique case (shed_q[2:0])
         3'b000:  shed_us = 10'd80;
         3'b001:  shed_us = 10'd160;
         3'b010:  shed_us = 10'd320;
         3'b011:  shed_us = 10'd640;
         3'b100:  shed_us = 10'd5;
         3'b101:  shed_us = 10'd10;
         3'b110:  shed_us = 10'd20;
         default: shed_us = 10'd40;
      endcase
   end

   always_comb begin
      cfg = '0;
      cfg.resistive_middle_drive =
         middle_q[tuning_pkg::BIT_RESISTIVE_MIDDLE];
      cfg.brief_middle_drive = middle_q[tuning_pkg::BIT_BRIEF_MIDDLE];
      cfg.low_state_phases = {1'b0, ph_code} + 4'h1;
      cfg.ramp_code = ramp;
      // ramp in 50 mV units: 3..10 then 12..26
      cfg.ramp_mv_div50 = ramp[3] ? 5'({1'b0, ramp} + {1'b0, ramp} - 5'h04)
                                  : {1'b0, ramp} + 5'h03;
      cfg.quick_response_pulse = (quick_q == tuning_pkg::QUICK_ON);
      cfg.gain_first  = balance_q[tuning_pkg::LSB_GAIN_FIRST +: 2];
      cfg.gain_second = gain2_q[1:0];
      cfg.gain_total_q4 = total_q4;
      cfg.balance_enable =
         ~balance_q[tuning_pkg::BIT_BALANCE_OFF_N];
      cfg.filter_half = balance_q[tuning_pkg::BIT_FILTER_HALF];
      cfg.overshoot_enable =
         balance_q[tuning_pkg::BIT_OVERSHOOT_EN];
      cfg.shed_delay_code = shed_q[2:0];
      cfg.shed_delay_us = shed_us;
   end

   // ----------------------------------------------------------------
   // per-phase middle drive
   // ----------------------------------------------------------------
   for (genvar i = 0; i < 8; i++) begin : g_lane
      tristate_hold u_hold (
         .clk_sys              (clk_sys),
         .resetn               (resetn),
         .brief_en             (cfg.brief_middle_drive),
         .resistive_en         (cfg.resistive_middle_drive),
         .diode_emulation_mode (diode_emulation_mode),
         .zero_current         (zero_current[i]),
         .middle_level         (middle_level[i]),
         .floating             (floating[i])
      );
   end

   // ----------------------------------------------------------------
   // power-state mid deglitch
   // ----------------------------------------------------------------
   logic        ps_mid;
   logic [6:0]  dg_target;
   logic [6:0]  dg_q;
   logic [6:0]  unit_q;
   logic        unit_tick;
   logic        shed_mode_q;
   logic        armed_q;

   assign ps_mid = ~ps_high & ~ps_low;
   // codes step 0.1 us doubling from code 1; 110 taken as 3.2 us
   assign dg_target = (deglitch_code == 3'b000) ? 7'h00
                    : 7'(7'h01 << (deglitch_code - 3'b001));
   assign unit_tick = (unit_q == 7'(tuning_pkg::DEGLITCH_UNIT_CYC - 1));

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         dg_q        <= 7'h00;
         unit_q      <= 7'h00;
         shed_mode_q <= 1'b0;
         armed_q     <= 1'b0;
      end else if (!ps_mid) begin
         dg_q        <= 7'h00;
         unit_q      <= 7'h00;
         shed_mode_q <= 1'b0;
         armed_q     <= 1'b1;
      end else if (!armed_q) begin
         // mid seen before any high or low level is not an entry
         shed_mode_q <= 1'b0;
      end else if (dg_q >= dg_target) begin
         shed_mode_q <= 1'b1;
      end else begin
         unit_q <= unit_tick ? 7'h00 : unit_q + 7'h01;
         if (unit_tick) begin
            dg_q <= dg_q + 7'h01;
         end
      end
   end

   assign automatic_phase_shedding = shed_mode_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_locked_write;
      req.we && lock_value == tuning_pkg::LOCK_CODE;
   endsequence

   property p_lock_holds;
      @(posedge clk_sys) disable iff (!resetn)
      s_locked_write |=> $stable(quick_q) && $stable(balance_q)
                      && $stable(middle_q) && $stable(phases_q)
                      && $stable(gain2_q) && $stable(shed_q);
   endproperty
   a_lock_holds: assert property (p_lock_holds)
      else $error("write landed while locked");

   property p_shed_gate;
      @(posedge clk_sys) disable iff (!resetn)
      req.we && req.addr == tuning_pkg::OFF_SHED_DELAY
      && !ps_high && !shed_unlock |=> $stable(shed_q);
   endproperty
   a_shed_gate: assert property (p_shed_gate)
      else $error("shed delay written without permission");

   property p_quick_off;
      @(posedge clk_sys) disable iff (!resetn)
      wr_quick && req.wdata == tuning_pkg::QUICK_OFF
      |=> !cfg.quick_response_pulse;
   endproperty
   a_quick_off: assert property (p_quick_off)
      else $error("quick response not disabled");

   property p_resist;
      @(posedge clk_sys) disable iff (!resetn)
      cfg.resistive_middle_drive |-> middle_level == 8'hff;
   endproperty
   a_resist: assert property (p_resist)
      else $error("resistive mid level missing");

   property p_phases;
      @(posedge clk_sys) disable iff (!resetn)
      wr_ph |=> cfg.low_state_phases
                == {1'b0, $past(req.wdata[6:4])} + 4'h1;
   endproperty
   a_phases: assert property (p_phases)
      else $error("phase count wrong");

   property p_balance;
      @(posedge clk_sys) disable iff (!resetn)
      wr_bal |=> cfg.balance_enable == !$past(req.wdata[2]);
   endproperty
   a_balance: assert property (p_balance)
      else $error("balance enable polarity wrong");

   property p_shed_needs_mid;
      @(posedge clk_sys) disable iff (!resetn)
      !ps_mid |=> !automatic_phase_shedding;
   endproperty
   a_shed_needs_mid: assert property (p_shed_needs_mid)
      else $error("shedding without mid level");

   property p_read_back;
      @(posedge clk_sys) disable iff (!resetn)
      req.addr == tuning_pkg::OFF_QUICK_RESP && !wr_quick
      |=> rdata == quick_q;
   endproperty
   a_read_back: assert property (p_read_back)
      else $error("read does not return stored value");

   property p_quick_on;
      @(posedge clk_sys) disable iff (!resetn)
      wr_quick && req.wdata == tuning_pkg::QUICK_ON
      |=> cfg.quick_response_pulse;
   endproperty
   a_quick_on: assert property (p_quick_on)
      else $error("quick response not enabled");

   property p_shed_write;
      @(posedge clk_sys) disable iff (!resetn)
      wr_shed |=> shed_q
                  == ($past(req.wdata) & tuning_pkg::MASK_SHED_DELAY);
   endproperty
   a_shed_write: assert property (p_shed_write)
      else $error("permitted shed delay write lost");

   property p_mid_deglitch;
      @(posedge clk_sys) disable iff (!resetn)
      !ps_mid ##1 ps_mid && deglitch_code != 3'b000
      |=> !automatic_phase_shedding;
   endproperty
   a_mid_deglitch: assert property (p_mid_deglitch)
      else $error("shedding entered before deglitch time");
endmodule

// [hw/tuning_pkg.sv]
// package: offsets, field layouts, reset values and timing for the tuning bank
package tuning_pkg;

   // register offsets
   localparam logic [7:0] OFF_LOCK         = 8'h00;
   localparam logic [7:0] OFF_SHED_UNLOCK  = 8'h2d;
   localparam logic [7:0] OFF_DEGLITCH     = 8'h4a;
   localparam logic [7:0] OFF_MIDDLE_DRIVE = 8'h4e;
   localparam logic [7:0] OFF_PHASES_RAMP  = 8'h4f;
   localparam logic [7:0] OFF_QUICK_RESP   = 8'h50;
   localparam logic [7:0] OFF_BALANCE      = 8'h55;
   localparam logic [7:0] OFF_SHED_DELAY   = 8'h5d;
   localparam logic [7:0] OFF_GAIN_SECOND  = 8'h5f;

   localparam logic [7:0] LOCK_CODE        = 8'ha6;

   // writable masks
   localparam logic [7:0] MASK_MIDDLE_DRIVE = 8'h07;
   localparam logic [7:0] MASK_PHASES_RAMP  = 8'h7f;
   localparam logic [7:0] MASK_QUICK_RESP   = 8'hff;
   localparam logic [7:0] MASK_BALANCE      = 8'h1f;
   localparam logic [7:0] MASK_SHED_DELAY   = 8'h07;
   localparam logic [7:0] MASK_GAIN_SECOND  = 8'h03;

   // reset values
   localparam logic [7:0] RST_MIDDLE_DRIVE = 8'h05;
   localparam logic [7:0] RST_PHASES_RAMP  = 8'h03;
   localparam logic [7:0] RST_QUICK_RESP   = 8'h8f;
   localparam logic [7:0] RST_BALANCE      = 8'h01;
   localparam logic [7:0] RST_SHED_DELAY   = 8'h00;
   localparam logic [7:0] RST_GAIN_SECOND  = 8'h00;

   // field positions
   localparam int BIT_BRIEF_MIDDLE     = 0;
   localparam int BIT_RESISTIVE_MIDDLE = 1;
   localparam int BIT_SHED_UNLOCK      = 2;
   localparam int BIT_OVERSHOOT_EN     = 0;
   localparam int BIT_FILTER_HALF      = 1;
   localparam int BIT_BALANCE_OFF_N    = 2;
   localparam int LSB_GAIN_FIRST       = 3;
   localparam int LSB_LOW_PHASES       = 4;
   localparam int LSB_DEGLITCH         = 3;

   localparam logic [7:0] QUICK_OFF = 8'h80;
   localparam logic [7:0] QUICK_ON  = 8'h8f;

   // timing at 200 MHz
   localparam int CLK_MHZ       = 200;
   localparam int HOLD_NS       = 200;
   localparam int HOLD_CYCLES   = HOLD_NS * CLK_MHZ / 1000;
   localparam int DEGLITCH_UNIT_NS = 100;
   localparam int DEGLITCH_UNIT_CYC = DEGLITCH_UNIT_NS * CLK_MHZ / 1000;

   // power-state input levels
   typedef enum logic [1:0] {PS_LOW, PS_MID, PS_HIGH} power_level_t;

   typedef struct packed {
      logic       we;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic       resistive_middle_drive;
      logic       brief_middle_drive;
      logic [3:0] low_state_phases;
      logic [4:0] ramp_mv_div50;
      logic [3:0] ramp_code;
      logic       quick_response_pulse;
      logic [1:0] gain_first;
      logic [1:0] gain_second;
      logic [3:0] gain_total_q4;
      logic       balance_enable;
      logic       filter_half;
      logic       overshoot_enable;
      logic [2:0] shed_delay_code;
      logic [9:0] shed_delay_us;
   } tuning_cfg_t;

endpackage

// [hw/tristate_hold.sv]
// one pwm lane: middle-drive hold after zero-current in diode emulation
`timescale 1ns/1ps
module tristate_hold (
   input  wire logic clk_sys,
   input  wire logic resetn,
   input  wire logic brief_en,
   input  wire logic resistive_en,
   input  wire logic diode_emulation_mode,
   input  wire logic zero_current,
   output logic      middle_level,
   output logic      floating
);
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic       zc_q;
   logic       start;
   logic       holding;

   assign start   = brief_en & diode_emulation_mode & zero_current & ~zc_q;
   assign holding = (cnt_q != 8'h00);
   assign cnt_d   = start ? 8'(tuning_pkg::HOLD_CYCLES)
                  : holding ? cnt_q - 8'h01 : cnt_q;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= 8'h00;
         zc_q  <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         zc_q  <= zero_current;
      end
   end

   // resistive drive overrides the brief window
   assign middle_level = resistive_en | holding;
   assign floating = ~resistive_en & ~holding & diode_emulation_mode
                   & zero_current & brief_en;

   property p_hold_len;
      @(posedge clk_sys) disable iff (!resetn)
      start && !resistive_en |=> holding [*8];
   endproperty
   a_hold_len: assert property (p_hold_len)
      else $error("middle hold shorter than expected");

   property p_hold_load;
      @(posedge clk_sys) disable iff (!resetn)
      start |=> cnt_q == 8'(tuning_pkg::HOLD_CYCLES);
   endproperty
   a_hold_load: assert property (p_hold_load)
      else $error("middle hold not loaded to full length");

   property p_hold_end;
      @(posedge clk_sys) disable iff (!resetn)
      cnt_q == 8'h01 && !start |=> !holding;
   endproperty
   a_hold_end: assert property (p_hold_end)
      else $error("middle hold longer than expected");

   property p_brief_off;
      @(posedge clk_sys) disable iff (!resetn)
      !brief_en && !holding |=> !holding;
   endproperty
   a_brief_off: assert property (p_brief_off)
      else $error("middle hold started while disabled");

   property p_resist_lane;
      @(posedge clk_sys) disable iff (!resetn)
      resistive_en |-> middle_level && !floating;
   endproperty
   a_resist_lane: assert property (p_resist_lane)
      else $error("lane not held at mid level");
endmodule

// [hw/level_sync.sv]
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module level_sync (
   input  wire logic clk_sys,
   input  wire logic resetn,
   input  wire logic pin,
   output logic      level
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         s1_q  <= 1'b0;
         s2_q  <= 1'b0;
         s3_q  <= 1'b0;
         level <= 1'b0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            level <= s3_q;
         end
      end
   end

   property p_hold_split;
      @(posedge clk_sys) disable iff (!resetn)
      s2_q != s3_q |=> $stable(level);
   endproperty
   a_hold_split: assert property (p_hold_split)
      else $error("synchronised level moved without agreement");

   property p_follow_agree;
      @(posedge clk_sys) disable iff (!resetn)
      s2_q == s3_q |=> level == $past(s3_q);
   endproperty
   a_follow_agree: assert property (p_follow_agree)
      else $error("synchronised level ignored agreement");
endmodule

// [verification/tuning_host.sv]
// parallel-bus host model that programs and reads the tuning bank
`timescale 1ns/1ps
module tuning_host (
   input  wire logic           clk_sys,
   input  wire logic [7:0]     rdata,
   output tuning_pkg::reg_req_t req
);
   initial req = '0;

   // -------------------------------------------------
   // bus cycles
   // -------------------------------------------------
   // strobe held across exactly one rising edge, so one write per call
   task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      req.we    = 1'b1;
      req.addr  = a;
      req.wdata = d;
      @(negedge clk_sys);
      req.we    = 1'b0;
      // released data must not look like the last value
      req.wdata = ~d;
   endtask

   // read data is registered, so it is taken one edge after the address
   task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_sys);
      req.we   = 1'b0;
      req.addr = a;
      @(negedge clk_sys);
      d = rdata;
   endtask
endmodule

// [verification/multiphase_tuning_registers_test.sv]
// self-checking bench for the tuning register bank
`timescale 1ns/1ps
module multiphase_tuning_registers_test;
   logic                    clk_sys;
   logic                    resetn;
   tuning_pkg::reg_req_t    req;
   logic [7:0]              rdata;
   logic [7:0]              lock_value;
   logic                    shed_unlock;
   logic [2:0]              deglitch_code;
   logic                    power_state_high;
   logic                    power_state_low;
   logic                    diode_mode;
   logic [7:0]              zero_current;
   logic [7:0]              middle_level;
   logic [7:0]              floating;
   logic                    shedding;
   tuning_pkg::tuning_cfg_t cfg;
   int                      n_mismatch;
   int                      compares;
   logic [7:0]              rdv;
   logic [7:0] offs[6] = '{8'h4e, 8'h4f, 8'h50, 8'h55, 8'h5d, 8'h5f};
   logic [7:0] rstv[6] = '{8'h05, 8'h03, 8'h8f, 8'h01, 8'h00, 8'h00};
   logic [7:0] msk[6]  = '{8'h07, 8'h7f, 8'hff, 8'h1f, 8'h07, 8'h03};
   int         shed_us[8] = '{80, 160, 320, 640, 5, 10, 20, 40};

   always #2.5 clk_sys = ~clk_sys;

   tuning_host u_host (.clk_sys(clk_sys), .rdata(rdata), .req(req));

   multiphase_tuning_registers u_dut (
      .clk_sys                 (clk_sys),
      .resetn                  (resetn),
      .req                     (req),
      .rdata                   (rdata),
      .lock_value              (lock_value),
      .shed_unlock             (shed_unlock),
      .deglitch_code           (deglitch_code),
      .power_state_high        (power_state_high),
      .power_state_low         (power_state_low),
      .diode_emulation_mode    (diode_mode),
      .zero_current            (zero_current),
      .middle_level            (middle_level),
      .floating                (floating),
      .automatic_phase_shedding(shedding),
      .cfg                     (cfg)
   );

   // -------------------------------------------------
   // helpers
   // -------------------------------------------------
   task automatic cmp(input string what, input logic [15:0] e,
                      input logic [15:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic conclude();
      if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [7:0] a, input logic [7:0] e);
      u_host.read_byte(a, rdv);
      cmp("readback", {8'h00, e}, {8'h00, rdv});
   endtask

   task automatic ticks(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   // -------------------------------------------------
   // scenarios
   // -------------------------------------------------
   task automatic t_reset();
      for (int i = 0; i < 6; i++) chk(offs[i], rstv[i]);
      chk(8'h60, 8'h00);
      cmp("brief", 16'h1, cfg.brief_middle_drive);
      cmp("resistive", 16'h0, cfg.resistive_middle_drive);
      cmp("phases", 16'h1, cfg.low_state_phases);
      cmp("ramp", 16'h6, cfg.ramp_mv_div50);
      cmp("quick", 16'h1, cfg.quick_response_pulse);
      cmp("gain", 16'h4, cfg.gain_total_q4);
      cmp("bal_en", 16'h1, cfg.balance_enable);
      cmp("filter", 16'h0, cfg.filter_half);
      cmp("overshoot", 16'h1, cfg.overshoot_enable);
      cmp("shed_us", 16'd80, cfg.shed_delay_us);
   endtask

   task automatic t_lock();
      power_state_high = 1'b1;
      lock_value = 8'ha6;
      ticks(5);
      for (int i = 0; i < 6; i++) begin
         u_host.write_byte(offs[i], 8'hff);
         chk(offs[i], rstv[i]);
      end
      lock_value = 8'h00;
      for (int i = 0; i < 6; i++) begin
         u_host.write_byte(offs[i], 8'hff);
         chk(offs[i], msk[i]);
         u_host.write_byte(offs[i], rstv[i]);
      end
   endtask

   task automatic t_shed();
      power_state_high = 1'b0;
      ticks(5);
      u_host.write_byte(8'h5d, 8'h03);
      chk(8'h5d, 8'h00);
      shed_unlock = 1'b1;
      u_host.write_byte(8'h5d, 8'h05);
      chk(8'h5d, 8'h05);
      shed_unlock = 1'b0;
      power_state_high = 1'b1;
      ticks(5);
      for (int c = 0; c < 8; c++) begin
         u_host.write_byte(8'h5d, 8'(c));
         cmp("shed_us", 16'(shed_us[c]), cfg.shed_delay_us);
      end
   endtask

   task automatic t_fields();
      logic [4:0] c;
      logic [3:0] f1;
      logic [3:0] tot;
      u_host.write_byte(8'h50, 8'h80);
      cmp("quick", 16'h0, cfg.quick_response_pulse);
      u_host.write_byte(8'h50, 8'h8f);
      cmp("quick", 16'h1, cfg.quick_response_pulse);
      for (c = 0; c < 16; c++) begin
         u_host.write_byte(8'h4f, {1'b0, c[2:0], c[3:0]});
         cmp("ramp", (c < 8) ? 16'(3 + c) : 16'(2 * c - 4),
             cfg.ramp_mv_div50);
         cmp("phases", 16'(c[2:0] + 1), cfg.low_state_phases);
      end
      for (c = 0; c < 16; c++) begin
         f1  = 4'd4 - 4'(c[3:2]);
         tot = (c[1:0] == 2'b01) ? 4'(2 * f1) :
               (c[1:0] == 2'b10) ? f1 >> 1 : f1;
         u_host.write_byte(8'h55, {3'b000, c[3:2], 3'b000});
         u_host.write_byte(8'h5f, {6'b0, c[1:0]});
         // odd first factor halved is not whole quarters
         if (!(c[1:0] == 2'b10 && f1[0]))
            cmp("gain", 16'(tot), cfg.gain_total_q4);
      end
      u_host.write_byte(8'h55, 8'h06);
      cmp("bal_en", 16'h0, cfg.balance_enable);
      cmp("filter", 16'h1, cfg.filter_half);
      cmp("overshoot", 16'h0, cfg.overshoot_enable);
      u_host.write_byte(8'h55, 8'h01);
      u_host.write_byte(8'h5f, 8'h00);
   endtask

   task automatic count_mid(input logic [7:0] zc, output int n);
      zero_current = 8'h00;
      ticks(4);
      zero_current = zc;
      n = 0;
      repeat (60) begin
         @(negedge clk_sys);
         if ((middle_level & zc) !== 8'h00) n++;
      end
   endtask

   task automatic t_hold();
      int n;
      diode_mode = 1'b1;
      count_mid(8'h01, n);
      cmp("hold_cycles", 16'(tuning_pkg::HOLD_CYCLES), 16'(n));
      cmp("float", 16'h1, floating[0]);
      u_host.write_byte(8'h4e, 8'h04);
      count_mid(8'h02, n);
      cmp("hold_off", 16'h0, 16'(n));
      u_host.write_byte(8'h4e, 8'h06);
      cmp("mid_all", 16'h00ff, {8'h00, middle_level});
      u_host.write_byte(8'h4e, 8'h05);
      zero_current = 8'h00;
      diode_mode = 1'b0;
   endtask

   task automatic t_aps();
      int t;
      int n;
      for (int c = 1; c < 4; c++) begin
         deglitch_code = 3'(c);
         // last pass enters mid from the low level
         power_state_high = (c != 3);
         power_state_low  = (c == 3);
         ticks(10);
         cmp("shed_idle", 16'h0, shedding);
         t = tuning_pkg::DEGLITCH_UNIT_CYC << (c - 1);
         power_state_high = 1'b0;
         power_state_low  = 1'b0;
         n = 0;
         while (shedding !== 1'b1 && n < 400) begin
            @(negedge clk_sys);
            n++;
         end
         if (n >= 400) begin
            cmp("shed_timeout", 16'h1, 16'h0);
            conclude();
         end
         // synchroniser and register add a few edges to the wait
         cmp("shed_wait", 16'h1, 16'(n > t && n <= t + 8));
      end
      power_state_high = 1'b1;
   endtask

   // -------------------------------------------------
   // main sequence
   // -------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      resetn = 1'b0;
      lock_value = 8'h00;
      shed_unlock = 1'b0;
      deglitch_code = 3'b010;
      power_state_high = 1'b1;
      power_state_low = 1'b0;
      diode_mode = 1'b0;
      zero_current = 8'h00;
      n_mismatch = 0;
      compares = 0;
      ticks(6);
      resetn = 1'b1;
      ticks(4);
      t_reset();
      t_lock();
      t_shed();
      t_fields();
      t_hold();
      t_aps();
      conclude();
   end
endmodule
